// file: rtl/smds_pkg.sv
// Package for the serial master sequencer: constants and carrier types
package smds_pkg;

   // Line width selection per phase
   localparam logic [1:0] SMDS_WIDTH_SINGLE = 2'h0;
   localparam logic [1:0] SMDS_WIDTH_DUAL = 2'h1;
   localparam logic [1:0] SMDS_WIDTH_QUAD = 2'h2;

   // Field widths and limits
   localparam int SMDS_GPC_W = 18;
   localparam int SMDS_BUF_WORDS = 16;
   localparam int SMDS_BUF_BITS = 32 * SMDS_BUF_WORDS;
   localparam int SMDS_FIFO_DEPTH = 16;
   localparam int SMDS_WORD_W = 32;

   // Timing: serial clock half period, and its count at 40 MHz
   localparam int SMDS_SYS_PERIOD_PS = 25000;
   localparam int SMDS_SCLK_HALF_NS = 100;
   localparam int SMDS_SCLK_HALF_CYC =
      (SMDS_SCLK_HALF_NS * 1000) / SMDS_SYS_PERIOD_PS;

   // Reset values
   localparam logic SMDS_CS_IDLE = 1'b1;
   localparam logic SMDS_SCLK_IDLE = 1'b0;

   typedef struct packed {
      logic full_duplex_select;
      logic wr_bit_order;
      logic cmd_enable;
      logic addr_enable;
      logic dummy_enable;
      logic dout_enable;
      logic din_enable;
      logic [1:0] cmd_width;
      logic [1:0] addr_width;
      logic [1:0] data_width;
      logic [3:0] cmd_length_field;
      logic [15:0] cmd_value_field;
      logic [4:0] addr_length_field;
      logic [31:0] addr_value_field;
      logic [7:0] dummy_length_field;
      logic [17:0] master_data_length;
      logic dma_transmit_enable;
      logic dma_receive_enable;
   } smds_cfg_type;

   typedef struct packed {
      logic [3:0] data_o;
      logic [3:0] data_oe;
      logic serial_clock_pin;
      logic cs_n;
   } smds_pins_type;

endpackage : smds_pkg

// file: rtl/smds_fifo.sv
// Synchronous FIFO with flush, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module smds_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic flush,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic not_full_q;
   logic empty_q;
   logic push;
   logic pop;
   logic [AW:0] cnt_d;

   assign push = in_valid && not_full_q;
   assign pop = out_ready && !empty_q;
   // Ready comes straight from a flop so the port is registered
   assign in_ready = not_full_q;
   assign out_valid = !empty_q;
   assign out_data = mem_q[rd_q];

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         not_full_q <= 1'b1;
         empty_q <= 1'b1;
      end else if (flush) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         not_full_q <= 1'b1;
         empty_q <= 1'b1;
      end else begin
         if (push) begin
            wr_q <= AW'(wr_q + 1'b1);
         end
         if (pop) begin
            rd_q <= AW'(rd_q + 1'b1);
         end
         cnt_q <= cnt_d;
         not_full_q <= (cnt_d != (AW+1)'(DEPTH));
         empty_q <= (cnt_d == '0);
      end
   end

   // Storage has no reset; only written entries are ever read
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule : smds_fifo
`default_nettype wire

// file: rtl/smds_master.sv
// Serial master sequencer: command, address, dummy and data phases
`timescale 1ns/1ps
`default_nettype none
module smds_master
   import smds_pkg::*;
#(
   parameter int HALF_CYC = SMDS_SCLK_HALF_CYC,
   parameter int FIFO_DEPTH = SMDS_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Control and configuration
   input wire smds_pkg::smds_cfg_type cfg,
   input wire logic transfer_start_bit,
   input wire logic dma_async_fifo_reset,
   input wire logic buffer_async_fifo_reset,
   input wire logic receive_async_fifo_reset,
   input wire logic [smds_pkg::SMDS_BUF_BITS-1:0] data_buffer_words,
   // Status
   output logic busy,
   output logic done,
   output logic [smds_pkg::SMDS_BUF_BITS-1:0] rx_buffer,
   // Transmit stream from DMA
   input wire logic dma_tx_valid,
   input wire logic [31:0] dma_tx_data,
   output logic dma_tx_ready,
   // Receive stream to DMA
   output logic dma_rx_valid,
   output logic [31:0] dma_rx_data,
   input wire logic dma_rx_ready,
   // Serial pins
   output smds_pkg::smds_pins_type pins,
   input wire logic [3:0] data_i
);
   import smds_pkg::*;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01, ST_CMD = 7'h02, ST_ADDR = 7'h04, ST_DUMMY = 7'h08,
      ST_DOUT = 7'h10, ST_DIN = 7'h20, ST_DONE = 7'h40
   } smds_state_type;

   localparam int DW = $clog2(HALF_CYC + 1);

   smds_state_type state_q;
   logic [SMDS_GPC_W-1:0] gpc_q;
   logic [DW-1:0] div_q;
   logic sclk_q;
   logic cs_n_q;
   logic busy_q;
   logic done_q;
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] dout_q;
   logic [3:0] doe_q;
   logic [31:0] txw_q;
   logic have_word_q;
   logic [SMDS_BUF_BITS-1:0] rxb_q;
   logic [31:0] rxw_q;
   logic rxv_q;

   logic [2:0] step;
   logic [SMDS_GPC_W-1:0] plen;
   logic last_grp;
   logic stall;
   logic tick;
   logic fifo_ready;
   logic fifo_pop;
   logic [31:0] fifo_data;
   logic fifo_valid;
   logic fd;
   logic capture;

   // Index of the k-th bit sent from a byte-grouped field (from top or
   // from bottom); the last group holds only the leftover bits
   function automatic logic [4:0] ca_idx(input logic [4:0] k,
      input logic [4:0] len, input logic msb, input logic top);
      logic [1:0] j;
      logic [2:0] b;
      logic [3:0] n;
      logic [4:0] base;
      j = k[4:3];
      b = k[2:0];
      n = (j < len[4:3]) ? 4'h8 : ({1'b0, len[2:0]} + 4'h1);
      base = top ? (5'h18 - {j, 3'h0}) : {j, 3'h0};
      if (msb) begin
         ca_idx = base + 5'(n) - 5'h1 - 5'(b);
      end else begin
         ca_idx = base + 5'h8 - 5'(n) + 5'(b);
      end
   endfunction : ca_idx

   // Position of data bit k within its byte, bytes ascending
   function automatic logic [2:0] bit_in_byte(input logic [2:0] b,
      input logic msb);
      bit_in_byte = msb ? (3'h7 - b) : b;
   endfunction : bit_in_byte

   function automatic logic [2:0] width_step(input logic [1:0] w);
      case (w)
         SMDS_WIDTH_DUAL: width_step = 3'h2;
         SMDS_WIDTH_QUAD: width_step = 3'h4;
         default: width_step = 3'h1;
      endcase
   endfunction : width_step

   // Next enabled phase after the given one, with only one data phase per transfer
   function automatic smds_state_type next_phase(input smds_state_type s,
      input smds_cfg_type c);
      logic after_cmd;
      logic after_addr;
      logic after_dummy;
      after_cmd = (s == ST_IDLE);
      after_addr = after_cmd || (s == ST_CMD);
      after_dummy = after_addr || (s == ST_ADDR);
      if (after_cmd && c.cmd_enable) begin
         next_phase = ST_CMD;
      end else if (after_addr && c.addr_enable) begin
         next_phase = ST_ADDR;
      end else if (after_dummy && c.dummy_enable) begin
         next_phase = ST_DUMMY;
      end else if (s != ST_DOUT && s != ST_DIN && c.full_duplex_select &&
                   (c.dout_enable || c.din_enable)) begin
         next_phase = ST_DOUT;
      end else if (s != ST_DOUT && s != ST_DIN && c.dout_enable) begin
         next_phase = ST_DOUT;
      end else if (s != ST_DOUT && s != ST_DIN && c.din_enable) begin
         next_phase = ST_DIN;
      end else begin
         next_phase = ST_DONE;
      end
   endfunction : next_phase

   assign fd = cfg.full_duplex_select;

   // Per-phase width and length; one counter times them all
   always_comb begin
      step = 3'h1;
      plen = '0;
      case (state_q)
         ST_CMD: begin
            step = width_step(cfg.cmd_width);
            plen = SMDS_GPC_W'(cfg.cmd_length_field);
         end
         ST_ADDR: begin
            step = width_step(cfg.addr_width);
            plen = SMDS_GPC_W'(cfg.addr_length_field);
         end
         ST_DUMMY: begin
            plen = SMDS_GPC_W'(cfg.dummy_length_field);
         end
         ST_DOUT, ST_DIN: begin
            step = fd ? 3'h1 : width_step(cfg.data_width);
            plen = cfg.master_data_length;
         end
         default: begin
            step = 3'h1;
            plen = '0;
         end
      endcase
   end

   assign last_grp = ({1'b0, gpc_q} + (SMDS_GPC_W+1)'(step)) >
                     {1'b0, plen};
   assign capture = (state_q == ST_DIN) || (state_q == ST_DOUT && fd);

   // Hold the serial clock low while a DMA word is missing or the
   // received word has not been taken, so no bit is ever lost
   assign stall = (!sclk_q && state_q == ST_DOUT &&
                   cfg.dma_transmit_enable && !have_word_q) ||
                  (!sclk_q && rxv_q);
   assign tick = busy_q && !stall && (div_q == DW'(HALF_CYC - 1));
   assign fifo_pop = state_q == ST_DOUT && cfg.dma_transmit_enable &&
                     !have_word_q && fifo_valid;

   smds_fifo #(
      .WIDTH(SMDS_WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .flush(dma_async_fifo_reset),
      .in_valid(dma_tx_valid),
      .in_data(dma_tx_data),
      .in_ready(fifo_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(fifo_pop)
   );

   // Pin inputs cross into the system clock through two flops
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
      end else begin
         sync1_q <= data_i;
         sync2_q <= sync1_q;
      end
   end

   // Serial clock divider
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         div_q <= '0;
      end else if (!busy_q || stall || tick) begin
         div_q <= '0;
      end else begin
         div_q <= DW'(div_q + 1'b1);
      end
   end

   // Sequencer: phases, shared counter, clock and chip select
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         gpc_q <= '0;
         sclk_q <= SMDS_SCLK_IDLE;
         cs_n_q <= SMDS_CS_IDLE;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (state_q == ST_IDLE) begin
            if (transfer_start_bit) begin
               state_q <= next_phase(ST_IDLE, cfg);
               gpc_q <= '0;
               cs_n_q <= 1'b0;
               busy_q <= 1'b1;
            end
         end else if (tick && state_q == ST_DONE) begin
            state_q <= ST_IDLE;
            cs_n_q <= SMDS_CS_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
         end else if (tick && !sclk_q) begin
            sclk_q <= 1'b1;
         end else if (tick) begin
            sclk_q <= 1'b0;
            if (last_grp) begin
               state_q <= next_phase(state_q, cfg);
               gpc_q <= '0;
            end else begin
               gpc_q <= gpc_q + SMDS_GPC_W'(step);
            end
         end
      end
   end

   // DMA transmit word holder; a new word is needed every 32 bits
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         txw_q <= '0;
         have_word_q <= 1'b0;
      end else if (fifo_pop) begin
         txw_q <= fifo_data;
         have_word_q <= 1'b1;
      end else if (state_q != ST_DOUT) begin
         have_word_q <= 1'b0;
      end else if (tick && sclk_q &&
                   (last_grp || (5'(gpc_q) + 5'(step)) == 5'h0)) begin
         have_word_q <= 1'b0;
      end
   end

   // Output lanes, recomputed every cycle from the phase and counter;
   // the first bit of a group goes on the highest lane in use
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dout_q <= 4'h0;
         doe_q <= 4'h0;
      end else begin
         dout_q <= 4'h0;
         doe_q <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            logic [SMDS_GPC_W-1:0] k;
            logic [1:0] lane;
            k = gpc_q + SMDS_GPC_W'(i);
            lane = 2'(step - 3'h1 - 3'(i));
            if (3'(i) < step) begin
               case (state_q)
                  ST_CMD: begin
                     dout_q[lane] <= cfg.cmd_value_field[4'(ca_idx(5'(k),
                        {1'b0, cfg.cmd_length_field}, cfg.wr_bit_order,
                        1'b0))];
                     doe_q[lane] <= 1'b1;
                  end
                  ST_ADDR: begin
                     dout_q[lane] <= cfg.addr_value_field[ca_idx(5'(k),
                        cfg.addr_length_field, cfg.wr_bit_order,
                        1'b1)];
                     doe_q[lane] <= 1'b1;
                  end
                  ST_DUMMY: begin
                     doe_q[lane] <= 1'b1;
                  end
                  ST_DOUT: begin
                     if (cfg.dma_transmit_enable) begin
                        dout_q[lane] <= txw_q[{k[4:3], bit_in_byte(k[2:0],
                           cfg.wr_bit_order)}];
                     end else begin
                        dout_q[lane] <= data_buffer_words[{k[8:3],
                           bit_in_byte(k[2:0], cfg.wr_bit_order)}];
                     end
                     doe_q[lane] <= 1'b1;
                  end
                  default: begin
                     doe_q[lane] <= 1'b0;
                  end
               endcase
            end
         end
      end
   end

   // Receive capture on the rising serial edge
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rxb_q <= '0;
         rxw_q <= '0;
         rxv_q <= 1'b0;
      end else begin
         if (buffer_async_fifo_reset) begin
            rxb_q <= '0;
         end
         if (receive_async_fifo_reset) begin
            rxv_q <= 1'b0;
         end else if (rxv_q && dma_rx_ready) begin
            rxv_q <= 1'b0;
         end
         if (tick && !sclk_q && capture) begin
            for (int i = 0; i < 4; i++) begin
               logic [SMDS_GPC_W-1:0] k;
               logic [1:0] lane;
               logic bitv;
               k = gpc_q + SMDS_GPC_W'(i);
               lane = (step == 3'h1) ? 2'h1 :
                      2'(step - 3'h1 - 3'(i));
               bitv = sync2_q[lane];
               if (3'(i) < step) begin
                  rxb_q[{k[8:3], bit_in_byte(k[2:0], cfg.wr_bit_order)}]
                     <= bitv;
                  rxw_q[{k[4:3], bit_in_byte(k[2:0], cfg.wr_bit_order)}]
                     <= bitv;
               end
            end
            if (cfg.dma_receive_enable &&
                (last_grp || (5'(gpc_q) + 5'(step)) == 5'h0)) begin
               rxv_q <= 1'b1;
            end
         end
      end
   end

   assign pins.data_o = dout_q;
   assign pins.data_oe = doe_q;
   assign pins.serial_clock_pin = sclk_q;
   assign pins.cs_n = cs_n_q;
   assign busy = busy_q;
   assign done = done_q;
   assign rx_buffer = rxb_q;
   assign dma_rx_valid = rxv_q;
   assign dma_rx_data = rxw_q;
   assign dma_tx_ready = fifo_ready;
endmodule : smds_master
`default_nettype wire

// file: test/smds_checker.sv
// Port-level assertions for the serial master sequencer
`timescale 1ns/1ps
`default_nettype none
module smds_checker
   import smds_pkg::*;
#(
   parameter int HALF_CYC = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Control
   input wire smds_pkg::smds_cfg_type cfg,
   input wire logic transfer_start_bit,
   input wire logic dma_async_fifo_reset,
   // Status and streams
   input wire logic busy,
   input wire logic done,
   input wire logic dma_tx_ready,
   input wire logic dma_rx_valid,
   input wire logic [31:0] dma_rx_data,
   input wire logic dma_rx_ready,
   // Serial pins
   input wire smds_pkg::smds_pins_type pins
);
   int hi_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Counts the high phase so its length is checked without long repeats
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hi_q <= 0;
      end else begin
         hi_q <= pins.serial_clock_pin ? hi_q + 1 : 0;
      end
   end
   start_taken_a: assert property (
      transfer_start_bit && !busy |=> busy && !pins.cs_n)
      else $error("start not taken");
   cs_fall_cause_a: assert property (
      $fell(pins.cs_n) |-> $past(transfer_start_bit))
      else $error("chip select fell without start");
   done_pulse_a: assert property (
      done |-> pins.cs_n && !busy && $past(busy) ##1 !done)
      else $error("bad done pulse");
   busy_end_a: assert property (
      $fell(busy) |-> done)
      else $error("busy ended without done");
   busy_select_a: assert property (
      busy |-> !pins.cs_n)
      else $error("chip select high while busy");
   idle_clock_a: assert property (
      pins.cs_n |-> !pins.serial_clock_pin)
      else $error("serial clock moves while deselected");
   fd_lanes_a: assert property (
      cfg.full_duplex_select |-> !pins.data_oe[1])
      else $error("input lane driven in full duplex");
   clock_high_a: assert property (
      $fell(pins.serial_clock_pin) |-> hi_q == HALF_CYC)
      else $error("wrong serial clock high time");
   data_hold_a: assert property (
      pins.serial_clock_pin |-> $stable(pins.data_o) && $stable(pins.data_oe))
      else $error("data moved while clock high");
   rx_hold_a: assert property (
      dma_rx_valid && !dma_rx_ready |=> dma_rx_valid && $stable(dma_rx_data))
      else $error("receive word dropped");
   tx_flush_a: assert property (
      dma_async_fifo_reset |-> ##[1:2] dma_tx_ready)
      else $error("transmit queue not cleared");
endmodule : smds_checker

bind smds_master smds_checker #(.HALF_CYC(HALF_CYC)) chk (
   .sys_clk(sys_clk), .resetn(resetn), .cfg(cfg),
   .transfer_start_bit(transfer_start_bit),
   .dma_async_fifo_reset(dma_async_fifo_reset), .busy(busy), .done(done),
   .dma_tx_ready(dma_tx_ready), .dma_rx_valid(dma_rx_valid),
   .dma_rx_data(dma_rx_data), .dma_rx_ready(dma_rx_ready), .pins(pins)
);
`default_nettype wire

// file: test/smds_slave_model.sv
// Behavioural serial slave: captures lane 0, answers on lane 1
`timescale 1ns/1ps
`default_nettype none
module smds_slave_model (
   // Serial side
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   // Bench side
   input wire logic [31:0] tx_word,
   output logic [63:0] got,
   output int cnt
);
   int idx = 31;
   initial begin
      miso = 1'b0;
      got = '0;
      cnt = 0;
   end
   always @(negedge cs_n) begin
      got = '0;
      cnt = 0;
      idx = 31;
      miso = tx_word[31];
   end
   always @(posedge sclk) begin
      if (!cs_n) begin
         got = {got[62:0], mosi};
         cnt++;
      end
   end
   // Next bit right after the fall, settled long before the next rise
   always @(negedge sclk) begin
      if (!cs_n) begin
         idx = (idx + 31) % 32;
         miso = tx_word[idx];
      end
   end
   // Released line flips so a stale bit never passes for data
   always @(posedge cs_n) miso = ~miso;
endmodule : smds_slave_model
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the serial master sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import smds_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   smds_cfg_type cfg = '0;
   logic start = 1'b0;
   logic [2:0] flush = 3'h0;
   logic [SMDS_BUF_BITS-1:0] words = '0;
   logic busy, done, txr, rxv, miso;
   logic [SMDS_BUF_BITS-1:0] rxb;
   logic txv = 1'b0;
   logic rxr = 1'b0;
   logic [31:0] txd = 32'h0;
   logic [31:0] rxd;
   smds_pins_type pins;
   logic [3:0] line;
   logic [63:0] got, e;
   int cnt, o, l;
   logic [31:0] pat = 32'h0;
   logic [31:0] seed = 32'h8AF86E1A;
   int bad_count = 0;
   int samples_checked = 0;
   smds_cfg_type c;

   always #12.5 sys_clk = ~sys_clk;
   assign line = (pins.data_oe & pins.data_o) |
      (~pins.data_oe & {~pins.data_o[3:2], miso, ~pins.data_o[0]});

   smds_master uut (
      .sys_clk(sys_clk), .resetn(resetn), .cfg(cfg),
      .transfer_start_bit(start), .dma_async_fifo_reset(flush[2]),
      .buffer_async_fifo_reset(flush[1]),
      .receive_async_fifo_reset(flush[0]), .data_buffer_words(words),
      .busy(busy), .done(done), .rx_buffer(rxb), .dma_tx_valid(txv),
      .dma_tx_data(txd), .dma_tx_ready(txr), .dma_rx_valid(rxv),
      .dma_rx_data(rxd), .dma_rx_ready(rxr), .pins(pins), .data_i(line)
   );
   smds_slave_model slave (
      .sclk(pins.serial_clock_pin), .cs_n(pins.cs_n),
      .mosi(pins.data_o[0]), .miso(miso), .tx_word(pat), .got(got),
      .cnt(cnt)
   );

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Wire order of a value, first bit ending up highest
   function automatic logic [63:0] ser_exp(input logic [31:0] v,
      input int n, input logic msb, input logic top);
      logic [63:0] r;
      int g, nb, b;
      r = '0;
      g = 0;
      while (n > 0) begin
         nb = n > 8 ? 8 : n;
         b = top ? 24 - 8 * g : 8 * g;
         for (int k = 0; k < nb; k++) begin
            r = {r[62:0], v[msb ? b + nb - 1 - k : b + 8 - nb + k]};
         end
         n -= nb;
         g++;
      end
      return r;
   endfunction : ser_exp

   // Bits that reach lane 0 when each group spans s lanes
   function automatic logic [63:0] lane0(input logic [63:0] v, input int n,
      input int s);
      logic [63:0] r;
      r = '0;
      for (int w = s - 1; w < n; w += s) begin
         r = {r[62:0], v[n - 1 - w]};
      end
      return r;
   endfunction : lane0

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task final_report();
      $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report

   // Queue is kept when it holds the words of this transfer
   task run(input smds_cfg_type cc);
      int k;
      @(posedge sys_clk);
      flush <= {~cc.dma_transmit_enable, 2'h3};
      cfg <= cc;
      @(posedge sys_clk);
      flush <= 3'h0;
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      check({63'h0, rxb === '0}, 64'h1);
      k = 0;
      while (done !== 1'b1 && k < 20000) begin
         @(posedge sys_clk);
         k++;
      end
      check({63'h0, k < 20000}, 64'h1);
   endtask : run

   // Receive stream stalls at random; each accepted word is compared
   always @(posedge sys_clk) begin
      if (rxv === 1'b1 && rxr === 1'b1) begin
         check(ser_exp(rxd, 32, cfg.wr_bit_order, 1'b0), {32'h0, pat});
      end
      rxr <= ^rnd();
   end

   initial begin
      #2000000;
      bad_count++;
      final_report();
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      for (o = 0; o < 2; o++) begin
         for (l = 0; l < 32; l++) begin
            c = '0;
            c.wr_bit_order = o[0];
            c.cmd_enable = 1'b1;
            c.addr_enable = 1'b1;
            c.cmd_length_field = l[3:0];
            c.addr_length_field = l[4:0];
            c.cmd_value_field = 16'(rnd());
            c.addr_value_field = rnd();
            run(c);
            e = ser_exp({16'h0, c.cmd_value_field}, l % 16 + 1, o[0], 1'b0);
            e = (e << (l + 1)) |
               ser_exp(c.addr_value_field, l + 1, o[0], 1'b1);
            check(got, e);
            check(64'(cnt), 64'(l % 16 + l + 2));
         end
      end
      for (l = 0; l < 3; l++) begin
         c = '0;
         c.cmd_enable = 1'b1;
         c.cmd_length_field = 4'h7;
         c.dummy_enable = 1'b1;
         c.dummy_length_field = (l == 0) ? 8'h00 : (l == 1) ? 8'hFF : 8'(rnd());
         run(c);
         check(64'(cnt), 64'(c.dummy_length_field) + 64'd9);
      end
      for (o = 0; o < 2; o++) begin
         words[63:0] <= {rnd(), rnd()};
         pat <= rnd();
         c = '0;
         c.wr_bit_order = o[0];
         c.dout_enable = 1'b1;
         c.master_data_length = 18'd63;
         run(c);
         e = ser_exp(words[31:0], 32, o[0], 1'b0) << 32;
         check(got, e | ser_exp(words[63:32], 32, o[0], 1'b0));
         c.dout_enable = 1'b0;
         c.din_enable = 1'b1;
         c.master_data_length = 18'd31;
         run(c);
         check(ser_exp(rxb[31:0], 32, o[0], 1'b0), {32'h0, pat});
         c.full_duplex_select = 1'b1;
         c.dout_enable = 1'b1;
         c.din_enable = 1'b0;
         c.dma_receive_enable = 1'b1;
         run(c);
         check(got, ser_exp(words[31:0], 32, o[0], 1'b0));
      end
      // Wide lanes: the slave sees lane 0, the last bit of each group
      c = '0;
      c.wr_bit_order = 1'b1;
      c.cmd_enable = 1'b1;
      c.addr_enable = 1'b1;
      c.dout_enable = 1'b1;
      c.cmd_width = SMDS_WIDTH_QUAD;
      c.addr_width = SMDS_WIDTH_DUAL;
      c.data_width = SMDS_WIDTH_QUAD;
      c.cmd_length_field = 4'hF;
      c.addr_length_field = 5'h1F;
      c.cmd_value_field = 16'(rnd());
      c.addr_value_field = rnd();
      c.master_data_length = 18'd31;
      run(c);
      e = ser_exp({16'h0, c.cmd_value_field}, 16, 1'b1, 1'b0);
      e = lane0(e, 16, 4) << 16;
      e = e | lane0(ser_exp(c.addr_value_field, 32, 1'b1, 1'b1), 32, 2);
      e = (e << 8) | lane0(ser_exp(words[31:0], 32, 1'b1, 1'b0), 32, 4);
      check(got, e);
      check(64'(cnt), 64'd28);
      // Fill the transmit queue with 16 words, check that it refuses more, then drain it serially
      @(posedge sys_clk);
      flush <= 3'h4;
      @(posedge sys_clk);
      flush <= 3'h0;
      txv <= 1'b1;
      for (l = 0; l < 16; l++) begin
         e = {32'h0, rnd()};
         txd <= e[31:0];
         @(posedge sys_clk);
      end
      txv <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check({63'h0, txr}, 64'h0);
      c = '0;
      c.wr_bit_order = 1'b1;
      c.dout_enable = 1'b1;
      c.dma_transmit_enable = 1'b1;
      c.master_data_length = 18'd511;
      run(c);
      check({32'h0, got[31:0]}, ser_exp(e[31:0], 32, 1'b1, 1'b0));
      check(64'(cnt), 64'd512);
      check({63'h0, txr}, 64'h1);
      final_report();
   end
endmodule : testbench
`default_nettype wire
